// ==== inc/psmal_pkg.sv ====
/*
 * Shared constants for the pressure sensor mode and alarm logic: data widths,
 * reset values, acquisition timing and interrupt source numbering.
 * Assumes a 50 MHz core clock; the front-end link clock is separate.
 */
`default_nettype none

package psmal_pkg;

    // ----------------------------------------------------------------------
    // Data formats
    // ----------------------------------------------------------------------
    localparam int PRES_W = 20;              // Pa in Q18.2, or m in Q16.4
    localparam int TEMP_W = 16;
    localparam int OFS_W  = 8;
    localparam int SEA_W  = 16;              // 2 Pa per step

    localparam logic [SEA_W-1:0] SEA_LEVEL_RESET = 16'hc5e7;   // 101326 Pa / 2

    // ----------------------------------------------------------------------
    // Acquisition timing
    // ----------------------------------------------------------------------
    localparam int  CLK_HZ        = 50_000_000;
    localparam int  TICK_S        = 1;
    localparam int  TICK_CYCLES   = CLK_HZ * TICK_S;
    localparam int  INTERVAL_W    = 15;
    localparam logic [INTERVAL_W-1:0] INTERVAL_MIN = 15'h0001;   // 1 s
    localparam logic [INTERVAL_W-1:0] INTERVAL_MAX = 15'h7e90;   // 9 h

    // ----------------------------------------------------------------------
    // Sample queue
    // ----------------------------------------------------------------------
    localparam int FIFO_DEPTH = 32;
    localparam int FIFO_AW    = 5;

    // ----------------------------------------------------------------------
    // Interrupt sources
    // ----------------------------------------------------------------------
    localparam int SRC_N      = 7;
    localparam int SRC_DRDY   = 0;
    localparam int SRC_FIFO   = 1;
    localparam int SRC_PDLT   = 2;
    localparam int SRC_PTGT   = 3;
    localparam int SRC_PWIN   = 4;
    localparam int SRC_TTGT   = 5;
    localparam int SRC_TWIN   = 6;

endpackage

`default_nettype wire

// ==== hw/psmal_core.sv ====
/*
 * Mode, acquisition, sample queue and alarm logic of a pressure, altitude
 * and temperature sensor.
 * Assumes a serial-bus slave elsewhere turns register accesses into the
 * plain ports below, and a front end on its own free-running link clock
 * that returns one compensated result set per start pulse.
 */
// Notes on behaviour
// - Standby: analog front end disabled unless a one-shot runs
// - Active: front end enabled, acquires data
// - Standby keeps stored results, new samples by one-shot only
// - Barometer results are unsigned 20-bit pascals
// - Altimeter results are signed 20-bit meters
// - Steps: 0.0625 m altitude, 0.25 Pa
// - Sea-level input 2 Pa/step, resets 101326
// - User offsets volatile; factory trim default
// - Raw mode: alarms, deltas, interrupts off
// - Periodic acquisition every 1 s to 9 h
// - Queue of 32 temperature+pressure entries
// - Queue flags watermark and overflow events
// - One-shot takes one sample, back to standby
// - Two pins, polarity and drive selectable
// - Any source routable to either pin
// - Pressure target flag at target, window edges
// - Zero window: flag only at target
// - Pressure window flag inside band, never zero
// - Barometer target and window are pressures
// - Temperature target flag at target, window edges
// - Temperature window flag inside band
// - Temperature presented as 16-bit result
// - Data-ready source from new-data or overwrite
// - Pressure change flag when step exceeds window
`timescale 1ns/1ps
`default_nettype none

module psmal_core #(
    parameter int TICK_CYCLES_P = psmal_pkg::TICK_CYCLES,
    parameter int FIFO_DEPTH_P  = psmal_pkg::FIFO_DEPTH
) (
    input  wire logic                            clk,
    input  wire logic                            srst,
    // Control and configuration
    input  wire logic                            standbyBar,
    input  wire logic                            oneShot,
    input  wire logic                            altimeterMode,
    input  wire logic                            rawMode,
    input  wire logic [psmal_pkg::INTERVAL_W-1:0] intervalSec,
    input  wire logic                            seaLevelWrite,
    input  wire logic [psmal_pkg::SEA_W-1:0]     seaLevelData,
    input  wire logic                            offsetWrite,
    input  wire logic [psmal_pkg::OFS_W-1:0]     offsetPres,
    input  wire logic [psmal_pkg::OFS_W-1:0]     offsetTemp,
    input  wire logic [psmal_pkg::OFS_W-1:0]     trimPres,
    input  wire logic [psmal_pkg::OFS_W-1:0]     trimTemp,
    input  wire logic [psmal_pkg::PRES_W-1:0]    pressureTargetValue,
    input  wire logic [psmal_pkg::PRES_W-1:0]    pressureWindowValue,
    input  wire logic [psmal_pkg::TEMP_W-1:0]    temperatureTargetValue,
    input  wire logic [psmal_pkg::TEMP_W-1:0]    temperatureWindowValue,
    input  wire logic [psmal_pkg::SRC_N-1:0]     srcEnable,
    input  wire logic [psmal_pkg::SRC_N-1:0]     srcRouteB,
    input  wire logic [psmal_pkg::SRC_N-1:0]     srcClear,
    input  wire logic                            irqActiveHighA,
    input  wire logic                            irqActiveHighB,
    input  wire logic                            irqOpenDrainA,
    input  wire logic                            irqOpenDrainB,
    input  wire logic                            dataStatusRead,
    input  wire logic                            fifoEnable,
    input  wire logic [psmal_pkg::FIFO_AW:0]     fifoWatermark,
    input  wire logic                            fifoPop,
    input  wire logic                            fifoFlagClear,
    // Results and status
    output logic [psmal_pkg::PRES_W-1:0]         pressureOut,
    output logic [psmal_pkg::TEMP_W-1:0]         temperatureOut,
    output logic [psmal_pkg::PRES_W-1:0]         pressureDelta,
    output logic [psmal_pkg::TEMP_W-1:0]         temperatureDelta,
    output logic                                 newDataFlag,
    output logic                                 dataOverwriteFlag,
    output logic [psmal_pkg::SRC_N-1:0]          srcFlags,
    output logic                                 acquiring,
    output logic [psmal_pkg::FIFO_AW:0]          fifoCount,
    output logic [psmal_pkg::PRES_W+psmal_pkg::TEMP_W-1:0] fifoData,
    output logic                                 fifoWatermarkFlag,
    output logic                                 fifoOverflowFlag,
    output logic                                 irqPinAOut,
    output logic                                 irqPinAOeN,
    output logic                                 irqPinBOut,
    output logic                                 irqPinBOeN,
    // Front-end link
    input  wire logic                            linkClk,
    output logic                                 feEnable,
    output logic                                 feStart,
    output logic [psmal_pkg::SEA_W-1:0]          feSeaLevel,
    input  wire logic                            feValid,
    input  wire logic [psmal_pkg::PRES_W-1:0]    fePressure,
    input  wire logic [psmal_pkg::PRES_W-1:0]    feAltitude,
    input  wire logic [psmal_pkg::TEMP_W-1:0]    feTemperature
);
    import psmal_pkg::*;

    localparam int ENTRY_W = PRES_W + TEMP_W;
    localparam int TICK_W  = $clog2(TICK_CYCLES_P);

    typedef enum logic [0:0] {PSMAL_IDLE, PSMAL_WAIT} psmal_state_t;

    // ----------------------------------------------------------------------
    // Helpers
    // ----------------------------------------------------------------------
    // Brings either result format onto one signed scale for comparison.
    function automatic logic signed [PRES_W+1:0] pWide(input logic [PRES_W-1:0] v,
                                                        input logic alt);
        return alt ? {{2{v[PRES_W-1]}}, v} : {2'b00, v};
    endfunction

    function automatic logic crossed(input logic signed [PRES_W+1:0] prev,
                                     input logic signed [PRES_W+1:0] cur,
                                     input logic signed [PRES_W+1:0] bnd);
        return (prev <= bnd && cur >= bnd) || (prev >= bnd && cur <= bnd);
    endfunction

    // ----------------------------------------------------------------------
    // Link domain: reset, enable and start crossing in, results crossing out
    // ----------------------------------------------------------------------
    logic       linkRstMeta, linkRst;
    logic       enMeta;
    logic [2:0] startSync;
    logic [1:0] ackSync;
    logic       startTgl, dataTgl, ackTgl;
    logic [ENTRY_W+PRES_W-1:0] linkHold;
    logic [SEA_W-1:0] cfgSeaLevel;

    always_ff @(posedge linkClk) begin
        linkRstMeta <= srst;
        linkRst     <= linkRstMeta;
    end

    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            enMeta    <= 1'b0;
            feEnable  <= 1'b0;
            startSync <= 3'h0;
            ackSync   <= 2'h0;
            feStart   <= 1'b0;
        end else begin
            enMeta    <= acquiring;
            feEnable  <= enMeta;
            startSync <= {startSync[1:0], startTgl};
            ackSync   <= {ackSync[0], ackTgl};
            feStart   <= startSync[2] ^ startSync[1];
        end
    end

    // The sea-level word is held stable by the core from the start toggle on,
    // so the front end may sample it once the start pulse is seen.
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            feSeaLevel <= SEA_LEVEL_RESET;
        end else if (startSync[2] ^ startSync[1]) begin
            feSeaLevel <= cfgSeaLevel;
        end
    end

    // A result arriving before the previous one is acknowledged is dropped.
    always_ff @(posedge linkClk) begin
        if (linkRst) begin
            dataTgl  <= 1'b0;
            linkHold <= '0;
        end else if (feValid && (dataTgl == ackSync[1])) begin
            dataTgl  <= ~dataTgl;
            linkHold <= {fePressure, feAltitude, feTemperature};
        end
    end

    // ----------------------------------------------------------------------
    // Core domain: result capture
    // ----------------------------------------------------------------------
    logic [2:0] dataSync;
    logic       resultTake;
    logic [PRES_W-1:0] heldPres, heldAlt;
    logic [TEMP_W-1:0] heldTemp;

    assign {heldPres, heldAlt, heldTemp} = linkHold;

    always_ff @(posedge clk) begin
        if (srst) begin
            dataSync <= 3'h0;
            ackTgl   <= 1'b0;
        end else begin
            dataSync <= {dataSync[1:0], dataTgl};
            if (dataSync[2] ^ dataSync[1]) begin
                ackTgl <= ~ackTgl;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Sea-level pressure and offsets
    // ----------------------------------------------------------------------
    logic [SEA_W-1:0] seaLevel;
    logic             offsetUser;
    logic [OFS_W-1:0] userOfsP, userOfsT;
    logic [OFS_W-1:0] ofsP, ofsT;

    always_ff @(posedge clk) begin
        if (srst) begin
            seaLevel <= SEA_LEVEL_RESET;
        end else if (seaLevelWrite) begin
            seaLevel <= seaLevelData;
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            offsetUser <= 1'b0;
            userOfsP   <= '0;
            userOfsT   <= '0;
        end else if (offsetWrite) begin
            offsetUser <= 1'b1;
            userOfsP   <= offsetPres;
            userOfsT   <= offsetTemp;
        end
    end

    assign ofsP = offsetUser ? userOfsP : trimPres;
    assign ofsT = offsetUser ? userOfsT : trimTemp;

    // ----------------------------------------------------------------------
    // Acquisition sequencing
    // ----------------------------------------------------------------------
    psmal_state_t      state;
    logic [TICK_W-1:0] tickCnt;
    logic [INTERVAL_W-1:0] secCnt, interval;
    logic              periodDue, oneShotBusy, startNow;

    assign interval = (intervalSec < INTERVAL_MIN) ? INTERVAL_MIN :
                      (intervalSec > INTERVAL_MAX) ? INTERVAL_MAX : intervalSec;
    assign periodDue = standbyBar && (secCnt >= interval);
    assign startNow  = (state == PSMAL_IDLE) && (periodDue || oneShot);
    assign resultTake = (dataSync[2] ^ dataSync[1]) && (state == PSMAL_WAIT);

    always_ff @(posedge clk) begin
        if (srst || !standbyBar) begin
            tickCnt <= '0;
            secCnt  <= '0;
        end else begin
            if (tickCnt == TICK_W'(TICK_CYCLES_P - 1)) begin
                tickCnt <= '0;
                if (secCnt < INTERVAL_MAX) begin
                    secCnt <= secCnt + 1'b1;
                end
            end else begin
                tickCnt <= tickCnt + 1'b1;
            end
            if (startNow) begin
                secCnt <= '0;
            end
        end
    end

    // Standby with no one-shot pending drops the wait, so a front end that
    // was switched off mid-conversion cannot hang the sequencer.
    always_ff @(posedge clk) begin
        if (srst) begin
            state       <= PSMAL_IDLE;
            oneShotBusy <= 1'b0;
            startTgl    <= 1'b0;
            cfgSeaLevel <= SEA_LEVEL_RESET;
        end else begin
            unique case (state)
                PSMAL_IDLE: begin
                    if (startNow) begin
                        state       <= PSMAL_WAIT;
                        oneShotBusy <= oneShot && !standbyBar;
                        startTgl    <= ~startTgl;
                        cfgSeaLevel <= seaLevel;
                    end
                end
                PSMAL_WAIT: begin
                    if (resultTake || (!standbyBar && !oneShotBusy)) begin
                        state       <= PSMAL_IDLE;
                        oneShotBusy <= 1'b0;
                    end
                end
            endcase
        end
    end

    assign acquiring = standbyBar || oneShotBusy;

    // ----------------------------------------------------------------------
    // Result formatting and deltas
    // ----------------------------------------------------------------------
    logic [PRES_W-1:0] newPres;
    logic [TEMP_W-1:0] newTemp;
    logic              havePrev;
    logic signed [PRES_W+1:0] prevW, curW, pTgtW, pWndW, pDiffW;
    logic signed [PRES_W+1:0] tPrevW, tCurW, tTgtW, tWndW;

    // Front-end words are already in the 0.25 Pa or 0.0625 m scale.
    always_comb begin
        newPres = altimeterMode ? heldAlt : heldPres;
        newTemp = heldTemp;
        if (!rawMode) begin
            newPres = newPres + PRES_W'(signed'(ofsP));
            newTemp = newTemp + TEMP_W'(signed'(ofsT));
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            pressureOut      <= '0;
            temperatureOut   <= '0;
            pressureDelta    <= '0;
            temperatureDelta <= '0;
            havePrev         <= 1'b0;
        end else if (resultTake) begin
            pressureOut    <= newPres;
            temperatureOut <= newTemp;
            havePrev       <= 1'b1;
            if (!rawMode) begin
                pressureDelta    <= newPres - pressureOut;
                temperatureDelta <= newTemp - temperatureOut;
            end
        end
    end

    // ----------------------------------------------------------------------
    // Alarm sources
    // ----------------------------------------------------------------------
    logic [SRC_N-1:0] srcSet, srcLive;
    logic             pWndZero, tWndZero;

    assign prevW  = pWide(pressureOut, altimeterMode);
    assign curW   = pWide(newPres, altimeterMode);
    assign pTgtW  = pWide(pressureTargetValue, altimeterMode);
    assign pWndW  = {2'b00, pressureWindowValue};
    assign pDiffW = curW - prevW;
    assign tPrevW = {{6{temperatureOut[TEMP_W-1]}}, temperatureOut};
    assign tCurW  = {{6{newTemp[TEMP_W-1]}}, newTemp};
    assign tTgtW  = {{6{temperatureTargetValue[TEMP_W-1]}}, temperatureTargetValue};
    assign tWndW  = {6'h00, temperatureWindowValue};
    assign pWndZero = (pressureWindowValue == '0);
    assign tWndZero = (temperatureWindowValue == '0);

    always_comb begin
        srcSet = '0;
        if (resultTake && !rawMode && havePrev) begin
            srcSet[SRC_PTGT] = crossed(prevW, curW, pTgtW) ||
                               (!pWndZero && (crossed(prevW, curW, pTgtW - pWndW) ||
                                              crossed(prevW, curW, pTgtW + pWndW)));
            srcSet[SRC_TTGT] = crossed(tPrevW, tCurW, tTgtW) ||
                               (!tWndZero && (crossed(tPrevW, tCurW, tTgtW - tWndW) ||
                                              crossed(tPrevW, tCurW, tTgtW + tWndW)));
            srcSet[SRC_PDLT] = ((pDiffW < 0) ? -pDiffW : pDiffW) > pWndW;
        end
        if (resultTake && !rawMode) begin
            srcSet[SRC_PWIN] = !pWndZero && curW >= pTgtW - pWndW &&
                               curW <= pTgtW + pWndW;
            srcSet[SRC_TWIN] = !tWndZero && tCurW >= tTgtW - tWndW &&
                               tCurW <= tTgtW + tWndW;
        end
    end

    // A set in the same cycle as its clear wins.
    always_ff @(posedge clk) begin
        if (srst) begin
            srcFlags <= '0;
        end else begin
            srcFlags <= srcSet | (srcFlags & ~srcClear);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            newDataFlag       <= 1'b0;
            dataOverwriteFlag <= 1'b0;
        end else begin
            newDataFlag       <= resultTake || (newDataFlag && !dataStatusRead);
            dataOverwriteFlag <= (resultTake && newDataFlag) ||
                                 (dataOverwriteFlag && !dataStatusRead);
        end
    end

    // ----------------------------------------------------------------------
    // Sample queue
    // ----------------------------------------------------------------------
    logic [ENTRY_W-1:0] fifoMem [FIFO_DEPTH_P];
    logic [FIFO_AW-1:0] wrPtr, rdPtr;
    logic               fifoPush, fifoDoPop;

    assign fifoPush  = resultTake && fifoEnable && !rawMode &&
                       (fifoCount != (FIFO_AW+1)'(FIFO_DEPTH_P));
    assign fifoDoPop = fifoPop && (fifoCount != '0);
    assign fifoData  = fifoMem[rdPtr];

    always_ff @(posedge clk) begin
        if (fifoPush) begin
            fifoMem[wrPtr] <= {newPres, newTemp};
        end
    end

    always_ff @(posedge clk) begin
        if (srst || !fifoEnable) begin
            wrPtr     <= '0;
            rdPtr     <= '0;
            fifoCount <= '0;
        end else begin
            if (fifoPush) begin
                wrPtr <= FIFO_AW'((wrPtr + 1'b1) % FIFO_DEPTH_P);
            end
            if (fifoDoPop) begin
                rdPtr <= FIFO_AW'((rdPtr + 1'b1) % FIFO_DEPTH_P);
            end
            fifoCount <= fifoCount + (FIFO_AW+1)'(fifoPush) - (FIFO_AW+1)'(fifoDoPop);
        end
    end

    always_ff @(posedge clk) begin
        if (srst) begin
            fifoWatermarkFlag <= 1'b0;
            fifoOverflowFlag  <= 1'b0;
        end else begin
            fifoWatermarkFlag <= (fifoEnable && fifoWatermark != '0 &&
                                  fifoCount >= fifoWatermark) ||
                                 (fifoWatermarkFlag && !fifoFlagClear);
            fifoOverflowFlag  <= (resultTake && fifoEnable && !rawMode && !fifoPush) ||
                                 (fifoOverflowFlag && !fifoFlagClear);
        end
    end

    // ----------------------------------------------------------------------
    // Interrupt pins
    // ----------------------------------------------------------------------
    logic [SRC_N-1:0] srcActive;
    logic             actA, actB, levelA, levelB;

    always_comb begin
        srcLive           = srcFlags;
        srcLive[SRC_DRDY] = newDataFlag || dataOverwriteFlag;
        srcLive[SRC_FIFO] = fifoWatermarkFlag || fifoOverflowFlag;
    end

    assign srcActive = rawMode ? '0 : (srcLive & srcEnable);
    assign actA   = |(srcActive & ~srcRouteB);
    assign actB   = |(srcActive & srcRouteB);
    assign levelA = irqActiveHighA ? actA : !actA;
    assign levelB = irqActiveHighB ? actB : !actB;

    // Open drain only pulls low; the high level is left to the pull-up.
    always_ff @(posedge clk) begin
        if (srst) begin
            irqPinAOut <= !irqActiveHighA;
            irqPinAOeN <= 1'b1;
            irqPinBOut <= !irqActiveHighB;
            irqPinBOeN <= 1'b1;
        end else begin
            irqPinAOut <= levelA;
            irqPinAOeN <= irqOpenDrainA && levelA;
            irqPinBOut <= levelB;
            irqPinBOeN <= irqOpenDrainB && levelB;
        end
    end

endmodule // psmal_core

`default_nettype wire

// ==== tb/psmal_fe_model.sv ====
/* Front-end model on the link clock: one result set per start pulse.
   Assumes the core raises feStart only while feEnable is high. */
`timescale 1ns/1ps
`default_nettype none
module psmal_fe_model import psmal_pkg::*; (
    input  wire logic                        linkClk, feEnable, feStart,
    input  wire logic [psmal_pkg::PRES_W-1:0] presIn,
    output logic                             feValid = 1'b0,
    output logic [psmal_pkg::PRES_W-1:0]     fePressure = 20'h00000, feAltitude = 20'h00000,
    output logic [psmal_pkg::TEMP_W-1:0]     feTemperature = 16'h0000);
    // Outside a result the data toggles, so a stale value never looks fresh.
    always_ff @(posedge linkClk) begin
        feValid <= feStart && feEnable;
        if (feStart && feEnable) begin
            {fePressure, feAltitude, feTemperature} <= {presIn, ~presIn, 16'h0100};
        end else begin
            {fePressure, feAltitude, feTemperature} <= ~{fePressure, feAltitude, feTemperature};
        end
    end
endmodule // psmal_fe_model
`default_nettype wire

// ==== tb/psmal_checker.sv ====
/* Port assertions for psmal_core.
   Assumes it is bound onto the core and sees only its ports. */
`timescale 1ns/1ps
`default_nettype none
module psmal_checker import psmal_pkg::*; (
    input wire logic clk, srst, linkClk, standbyBar, rawMode, acquiring, feEnable,
    input wire logic irqActiveHighA, irqOpenDrainA, irqOpenDrainB, fifoWatermarkFlag,
    input wire logic irqPinAOut, irqPinAOeN, irqPinBOut, irqPinBOeN,
    input wire logic [psmal_pkg::PRES_W-1:0] pressureWindowValue,
    input wire logic [psmal_pkg::SRC_N-1:0]  srcFlags,
    input wire logic [psmal_pkg::FIFO_AW:0]  fifoWatermark, fifoCount);
    a_raw_quiet: assert property (@(posedge clk) disable iff (srst)
        rawMode |=> (srcFlags & ~$past(srcFlags)) == 7'h00) else $error("raw flag rose");
    a_raw_pins: assert property (@(posedge clk) disable iff (srst)
        rawMode [*2] |-> irqPinAOut == !irqActiveHighA) else $error("raw pin active");
    a_pwin_zero: assert property (@(posedge clk) disable iff (srst)
        $rose(srcFlags[SRC_PWIN]) |-> $past(pressureWindowValue) != 20'h00000)
        else $error("zero window flag");
    a_fe_off: assert property (@(posedge linkClk) disable iff (srst)
        !acquiring [*4] |=> !feEnable) else $error("front end on");
    a_shot_ends: assert property (@(posedge clk) disable iff (srst)
        $rose(acquiring) && !standbyBar |-> ##[1:300] !acquiring) else $error("shot stuck");
    a_pp_drive: assert property (@(posedge clk) disable iff (srst)
        !irqOpenDrainA |=> !irqPinAOeN) else $error("pin not driven");
    a_od_level: assert property (@(posedge clk) disable iff (srst)
        irqOpenDrainB |=> irqPinBOeN == irqPinBOut) else $error("pin drives high");
    a_wm_flag: assert property (@(posedge clk) disable iff (srst)
        fifoWatermark != 6'h00 && fifoCount >= fifoWatermark |-> ##[1:2] fifoWatermarkFlag)
        else $error("no watermark flag");
endmodule // psmal_checker
bind psmal_core psmal_checker u_psmal_checker (.*);
`default_nettype wire

// ==== tb/tb_top.sv ====
/* Scenario bench for psmal_core with the front-end model.
   Assumes the checker binds itself to the core. */
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    import psmal_pkg::*;
    logic clk = 0, srst = 1, linkClk = 0, standbyBar = 0, oneShot = 0, altimeterMode = 0;
    logic rawMode = 0, seaLevelWrite = 0, offsetWrite = 0, irqActiveHighA = 1, irqActiveHighB = 0;
    logic irqOpenDrainA = 0, irqOpenDrainB = 1, dataStatusRead = 0, fifoEnable = 1, fifoPop = 0;
    logic fifoFlagClear = 0, newDataFlag, dataOverwriteFlag, acquiring, fifoWatermarkFlag;
    logic fifoOverflowFlag, irqPinAOut, irqPinAOeN, irqPinBOut, irqPinBOeN, feEnable, feStart;
    logic feValid;
    logic [14:0] intervalSec = 15'h0001;
    logic [15:0] seaLevelData = 16'h0000, feSeaLevel, temperatureTargetValue = 16'h0000;
    logic [15:0] temperatureWindowValue = 16'h0000, temperatureOut, temperatureDelta, feTemperature;
    logic [7:0]  offsetPres = 8'h00, offsetTemp = 8'h00, trimPres = 8'h01, trimTemp = 8'h00;
    logic [19:0] pressureTargetValue = 20'h01000, pressureWindowValue = 20'h00000;
    logic [19:0] presIn = 20'h00000, pressureOut, pressureDelta, fePressure, feAltitude;
    logic [6:0]  srcEnable = 7'h7f, srcRouteB = 7'h00, srcClear = 7'h00, srcFlags;
    logic [5:0]  fifoWatermark = 6'h02, fifoCount;
    logic [35:0] fifoData;
    int miscompares = 0, comparisons = 0;
    psmal_core #(.TICK_CYCLES_P(10)) u_psmal_core (.*);
    psmal_fe_model u_psmal_fe_model (.*);
    always #10 clk = ~clk;
    always #32 linkClk = ~linkClk;
    task automatic check(input logic [35:0] got, input logic [35:0] exp);
        comparisons++;
        if (got !== exp) begin
            miscompares++;
            $display("unexpected at %0t: %0h vs %0h", $time, got, exp);
        end
    endtask
    task automatic tick(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask
    task automatic shot(input logic [19:0] p);
        presIn = p;
        oneShot = 1;
        tick(1);
        oneShot = 0;
        for (int i = 0; i < 300 && acquiring !== 1'b0; i++) tick(1);
        check(acquiring, 1'b0);
        tick(4);
        dataStatusRead = 1;
        tick(1);
        dataStatusRead = 0;
    endtask
    task automatic clear_flags;
        srcClear = 7'h7f;
        tick(1);
        srcClear = 7'h00;
    endtask
    task automatic t_first;
        check(feSeaLevel, 16'hc5e7);
        shot(20'h00f00);
        check(pressureOut, 20'h00f01);
        check(fifoData, 36'h00f010100);
    endtask
    task automatic t_cross;
        seaLevelData = 16'h1234;
        seaLevelWrite = 1;
        tick(1);
        seaLevelWrite = 0;
        shot(20'h01100);
        check(srcFlags, 7'h0c);
        check({irqPinAOut, irqPinBOut, irqPinBOeN, fifoWatermarkFlag}, 4'hf);
        check(feSeaLevel, 16'h1234);
    endtask
    task automatic t_window;
        pressureWindowValue = 20'h00400;
        clear_flags;
        shot(20'h01200);
        check(srcFlags, 7'h10);
        tick(100);
        check({newDataFlag, acquiring, pressureOut}, 22'h001201);
    endtask
    task automatic t_periodic;
        standbyBar = 1;
        tick(200);
        check({newDataFlag, dataOverwriteFlag}, 2'h3);
        standbyBar = 0;
        tick(60);
    endtask
    task automatic t_alt;
        altimeterMode = 1;
        pressureWindowValue = 20'h00000;
        clear_flags;
        shot(20'h000ff);
        check(pressureOut, 20'hfff01);
        check(srcFlags, 7'h0c);
        altimeterMode = 0;
    endtask
    task automatic t_raw;
        rawMode = 1;
        fifoEnable = 0;
        clear_flags;
        shot(20'h00800);
        check({srcFlags, fifoCount, irqPinAOut}, 14'h0000);
        check(pressureDelta, 20'hfed00);
    endtask
    task automatic summarize;
        $display("comparisons %0d miscompares %0d", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    // The link side takes reset through its own synchroniser, so the bench waits for it.
    initial begin
        tick(6);
        srst = 0;
        tick(12);
        t_first;
        t_cross;
        t_window;
        t_periodic;
        t_alt;
        t_raw;
        summarize;
    end
    initial begin
        #200us;
        miscompares++;
        summarize;
    end
endmodule // tb_top
`default_nettype wire
